// ===== ext_mem_sdram_bus_release.sv
// SDRAM burst controller with outside-master bus release handshake.
// Assumes SDRAM on one chip-enable space and a user port giving one word per tick.
//
// Contract
// - Shared strobe pins carry SDRAM row/column/write strobes
// - Use SDRAM burst counter, four-word incrementing default
// - Random or reversed order interrupts running burst
// - Any burst type streams without gaps
// - Float bus no sooner than two periods
// - Float first, then acknowledge within two periods
// - Redrive bus between two and seven periods
// - Drop acknowledge within two periods of redrive
// - Pending transactions finish before acknowledge
// - Idle interface releases with least delay
// - Inhibit input withholds release indefinitely
// - Floated group: enables, data, address, strobes
`include "sdram_hold_params.svh"
module ext_mem_sdram_bus_release #(
  parameter int ECLK_HALF = `ECLK_HALF_DEF,
  parameter int CAS_LAT = `CAS_LAT_DEF,
  parameter int REFRESH_TICKS = `REFRESH_TICKS_DEF,
  parameter logic [1:0] CE_SEL = 2'h0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic bus_release_req_n,
  input wire logic release_inhibit,
  output logic bus_release_ack_n,
  output logic ext_mem_clock_out,
  output sdram_hold_pkg::pins_t ext_pins,
  output logic ext_bus_oe,
  input wire logic [`DATA_W-1:0] ext_data_in,
  output logic [`DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [`ACC_ADDR_W-1:0] acc_addr,
  input wire logic [`DATA_W-1:0] acc_wdata,
  input wire logic [3:0] acc_be_n,
  output logic acc_ready,
  output logic rd_valid,
  output logic [`DATA_W-1:0] rd_data
);
  // Margin of one tick covers the unknown phase of the first tick
  localparam logic [2:0] FLOAT_TICKS = 3'(`FLOAT_MIN_E + 1);
  localparam logic [2:0] DRIVE_TICKS = 3'(`DRIVE_MIN_E + 1);
  localparam logic [1:0] BEATS_LEFT = 2'(`BURST_WORDS - 1);

  logic rst_a_ff;
  logic rst_sync_n;
  logic tick;
  logic req_n_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_a_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_sync_n <= rst_a_ff;
    end
  end

  eclk_divider #(.HALF(ECLK_HALF)) u_div (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .clk_out(ext_mem_clock_out),
    .tick(tick)
  );

  pin_sync3 #(.RESET_VAL(1'b1)) u_req_sync (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .pin(bus_release_req_n),
    .level(req_n_s)
  );

  sdram_hold_pkg::state_t state_ff, nxt_state;
  sdram_hold_pkg::pins_t pins_ff, nxt_pins;
  logic bus_oe_ff, nxt_bus_oe;
  logic ack_n_ff, nxt_ack_n;
  logic row_open_ff, nxt_row_open;
  logic [`BANK_W-1:0] bank_ff, nxt_bank;
  logic [`ROW_W-1:0] row_ff, nxt_row;
  logic [`COL_W-1:0] col_ff, nxt_col;
  logic last_wr_ff, nxt_last_wr;
  logic [1:0] beats_ff, nxt_beats;
  logic [CAS_LAT-1:0] rd_pipe_ff;
  logic rd_issue;
  logic [`DATA_W-1:0] dout_ff, nxt_dout;
  logic dout_oe_ff, nxt_dout_oe;
  logic [2:0] lo_cnt_ff;
  logic [2:0] hi_cnt_ff;
  logic [15:0] ref_cnt_ff;
  logic ref_due_ff;
  logic ref_issue;
  logic accept;

  wire [`BANK_W-1:0] a_bank = acc_addr[`ACC_ADDR_W-1 -: `BANK_W];
  wire [`ROW_W-1:0] a_row = acc_addr[`COL_W +: `ROW_W];
  wire [`COL_W-1:0] a_col = acc_addr[`COL_W-1:0];
  wire row_hit = row_open_ff && (a_bank == bank_ff) && (a_row == row_ff);
  // Next word of the running burst, not past its aligned four-word group
  wire seq_word = (beats_ff != 2'h0) && (acc_write == last_wr_ff)
    && (a_col == col_ff + `COL_W'(1)) && (a_col[1:0] != 2'h0);
  wire rd_busy = (|rd_pipe_ff) || ((beats_ff != 2'h0) && !last_wr_ff);
  wire hold_want = !req_n_s && !release_inhibit;
  wire stop_req = hold_want || ref_due_ff;
  wire wr_blocked = acc_write && rd_busy;
  wire [3:0] ce_sel_n = ~(4'h1 << CE_SEL);

  function automatic sdram_hold_pkg::pins_t mk_cmd(input sdram_hold_pkg::cmd_t c,
      input logic [19:0] addr, input logic [3:0] ce_n, input logic [3:0] be_n);
    sdram_hold_pkg::pins_t p;
    p.chip_enable_n = ce_n;
    p.byte_enable_n = be_n;
    p.ext_word_address = addr;
    // strobe pins act as row, column, write
    p.outen_rowstrobe_pin = c[2];
    p.read_colstrobe_pin = c[1];
    p.write_strobe_pin = c[0];
    return p;
  endfunction : mk_cmd

  wire [19:0] act_addr = {6'h00, a_bank, a_row};
  wire [19:0] col_addr = {6'h00, a_bank, 4'h0, a_col};
  wire [19:0] close_one_addr = {6'h00, bank_ff, 12'h000};
  wire [19:0] close_all_addr = 20'h0_0001 << `AP_BIT;

  always_comb begin
    nxt_state = state_ff;
    nxt_pins = mk_cmd(sdram_hold_pkg::nop_cmd, pins_ff.ext_word_address, 4'hF, 4'hF);
    nxt_bus_oe = bus_oe_ff;
    nxt_ack_n = ack_n_ff;
    nxt_row_open = row_open_ff;
    nxt_bank = bank_ff;
    nxt_row = row_ff;
    nxt_col = col_ff;
    nxt_last_wr = last_wr_ff;
    nxt_beats = (beats_ff != 2'h0) ? beats_ff - 2'h1 : 2'h0;
    nxt_dout = dout_ff;
    nxt_dout_oe = 1'b0;
    rd_issue = 1'b0;
    ref_issue = 1'b0;
    accept = 1'b0;
    case (state_ff)
      sdram_hold_pkg::ST_INIT_PRE: begin
        nxt_pins = mk_cmd(sdram_hold_pkg::close_bank_cmd, close_all_addr, ce_sel_n, 4'hF);
        nxt_state = sdram_hold_pkg::ST_INIT_REF;
      end
      sdram_hold_pkg::ST_INIT_REF: begin
        nxt_pins = mk_cmd(sdram_hold_pkg::refresh_cmd, 20'h0_0000, ce_sel_n, 4'hF);
        nxt_state = sdram_hold_pkg::ST_INIT_MRS;
      end
      sdram_hold_pkg::ST_INIT_MRS: begin
        // mode word selects four-word incrementing bursts
        nxt_pins = mk_cmd(sdram_hold_pkg::mode_reg_set_cmd, `MODE_WORD, ce_sel_n, 4'hF);
        nxt_state = sdram_hold_pkg::ST_RUN;
      end
      sdram_hold_pkg::ST_RUN: begin
        if (stop_req) begin
          // let bursts and read returns drain first
          if (rd_busy || (beats_ff != 2'h0)) begin
            if (last_wr_ff) begin
              nxt_dout_oe = 1'b1;
            end
          end else if (row_open_ff) begin
            nxt_pins = mk_cmd(sdram_hold_pkg::close_bank_cmd, close_all_addr, ce_sel_n, 4'hF);
            nxt_row_open = 1'b0;
          end else if (ref_due_ff) begin
            nxt_pins = mk_cmd(sdram_hold_pkg::refresh_cmd, 20'h0_0000, ce_sel_n, 4'hF);
            ref_issue = 1'b1;
          end else begin
            // nothing pending, go straight to release
            nxt_state = sdram_hold_pkg::ST_HOLD_WAIT;
          end
        end else if (acc_valid && row_hit && !wr_blocked) begin
          accept = 1'b1;
          nxt_col = a_col;
          nxt_last_wr = acc_write;
          nxt_dout = acc_wdata;
          nxt_dout_oe = acc_write;
          rd_issue = !acc_write;
          if (seq_word) begin
            // burst counter advances, no command, no gap
            nxt_pins = mk_cmd(sdram_hold_pkg::nop_cmd, pins_ff.ext_word_address, ce_sel_n,
              acc_be_n);
          end else begin
            // new column interrupts the running burst
            nxt_pins = mk_cmd(acc_write ? sdram_hold_pkg::write_cmd : sdram_hold_pkg::read_cmd,
              col_addr, ce_sel_n, acc_be_n);
            nxt_beats = BEATS_LEFT;
          end
        end else if (acc_valid && row_open_ff && !row_hit && !rd_busy && beats_ff == 2'h0) begin
          nxt_pins = mk_cmd(sdram_hold_pkg::close_bank_cmd, close_one_addr, ce_sel_n, 4'hF);
          nxt_row_open = 1'b0;
        end else if (acc_valid && !row_open_ff) begin
          nxt_pins = mk_cmd(sdram_hold_pkg::row_activate_cmd, act_addr, ce_sel_n, 4'hF);
          nxt_row_open = 1'b1;
          nxt_bank = a_bank;
          nxt_row = a_row;
        end else if (beats_ff != 2'h0 && last_wr_ff) begin
          // Unused tail of a write burst is masked off
          nxt_dout_oe = 1'b1;
        end
      end
      sdram_hold_pkg::ST_HOLD_WAIT: begin
        // inhibit or withdrawn request returns to service
        if (!hold_want) begin
          nxt_state = sdram_hold_pkg::ST_RUN;
        // float only after enough low ticks
        end else if (lo_cnt_ff >= FLOAT_TICKS) begin
          nxt_bus_oe = 1'b0;
          nxt_state = sdram_hold_pkg::ST_FLOATED;
        end
      end
      sdram_hold_pkg::ST_FLOATED: begin
        nxt_ack_n = 1'b0;
        nxt_state = sdram_hold_pkg::ST_HELD;
      end
      sdram_hold_pkg::ST_HELD: begin
        // redrive after three high ticks, inside two to seven periods
        if (req_n_s && hi_cnt_ff >= DRIVE_TICKS) begin
          nxt_bus_oe = 1'b1;
          nxt_state = sdram_hold_pkg::ST_REDRIVE;
        end
      end
      sdram_hold_pkg::ST_REDRIVE: begin
        // drop acknowledge one tick after redrive
        nxt_ack_n = 1'b1;
        nxt_state = sdram_hold_pkg::ST_RUN;
      end
      default: begin
        nxt_state = sdram_hold_pkg::ST_INIT_PRE;
      end
    endcase
  end

  assign acc_ready = tick && accept;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff <= sdram_hold_pkg::ST_INIT_PRE;
      pins_ff <= '1;
      bus_oe_ff <= 1'b1;
      ack_n_ff <= 1'b1;
      row_open_ff <= 1'b0;
      bank_ff <= '0;
      row_ff <= '0;
      col_ff <= '0;
      last_wr_ff <= 1'b0;
      beats_ff <= 2'h0;
      dout_ff <= '0;
      dout_oe_ff <= 1'b0;
    end else if (tick) begin
      state_ff <= nxt_state;
      pins_ff <= nxt_pins;
      bus_oe_ff <= nxt_bus_oe;
      ack_n_ff <= nxt_ack_n;
      row_open_ff <= nxt_row_open;
      bank_ff <= nxt_bank;
      row_ff <= nxt_row;
      col_ff <= nxt_col;
      last_wr_ff <= nxt_last_wr;
      beats_ff <= nxt_beats;
      dout_ff <= nxt_dout;
      dout_oe_ff <= nxt_dout_oe;
    end
  end

  // Read returns: data is sampled at the tick, where the memory clock gives it settled
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_pipe_ff <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (tick) begin
        rd_pipe_ff <= {rd_pipe_ff[CAS_LAT-2:0], rd_issue};
        if (rd_pipe_ff[CAS_LAT-1]) begin
          rd_valid <= 1'b1;
          rd_data <= ext_data_in;
        end
      end
    end
  end

  // Request level counted in ticks; refresh due flag set wins over clear
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lo_cnt_ff <= 3'h0;
      hi_cnt_ff <= 3'h0;
      ref_cnt_ff <= 16'h0000;
      ref_due_ff <= 1'b0;
    end else if (tick) begin
      lo_cnt_ff <= req_n_s ? 3'h0 : ((lo_cnt_ff == `CNT_SAT) ? lo_cnt_ff : lo_cnt_ff + 3'h1);
      hi_cnt_ff <= !req_n_s ? 3'h0 : ((hi_cnt_ff == `CNT_SAT) ? hi_cnt_ff : hi_cnt_ff + 3'h1);
      if (ref_cnt_ff == 16'(REFRESH_TICKS - 1)) begin
        ref_cnt_ff <= 16'h0000;
        ref_due_ff <= 1'b1;
      end else begin
        ref_cnt_ff <= ref_cnt_ff + 16'h0001;
        if (ref_issue) begin
          ref_due_ff <= 1'b0;
        end
      end
    end
  end

  // one enable floats enables, address, strobes and data together
  assign ext_bus_oe = bus_oe_ff;
  assign ext_pins = pins_ff;
  assign ext_data_out = dout_ff;
  assign ext_data_oe = dout_oe_ff && bus_oe_ff;
  assign bus_release_ack_n = ack_n_ff;

  // Checks
  localparam int E_CYC = 2 * ECLK_HALF;
  localparam int ACK_WIN = `ACK_MAX_E * E_CYC;
  logic [15:0] lo_mclk_ff;
  logic [15:0] hi_mclk_ff;
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lo_mclk_ff <= 16'h0000;
      hi_mclk_ff <= 16'h0000;
    end else begin
      lo_mclk_ff <= req_n_s ? 16'h0000 : lo_mclk_ff + {15'h0000, lo_mclk_ff != 16'hFFFF};
      hi_mclk_ff <= !req_n_s ? 16'h0000 : hi_mclk_ff + {15'h0000, hi_mclk_ff != 16'hFFFF};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  chk_float_min_delay: assert property (
    $fell(ext_bus_oe) |-> lo_mclk_ff >= 16'(`FLOAT_MIN_E * E_CYC))
    else $error("bus floated too soon after request");
  chk_ack_after_float: assert property (
    $fell(bus_release_ack_n) |-> !ext_bus_oe && $past(!ext_bus_oe))
    else $error("acknowledge before bus floated");
  chk_ack_window: assert property (
    $fell(ext_bus_oe) |-> ##[1:ACK_WIN] !bus_release_ack_n)
    else $error("acknowledge late after float");
  chk_redrive_window: assert property (
    $rose(ext_bus_oe) |-> hi_mclk_ff >= 16'(`DRIVE_MIN_E * E_CYC)
      && hi_mclk_ff <= 16'(`DRIVE_MAX_E * E_CYC))
    else $error("redrive outside allowed window");
  chk_ack_release: assert property (
    $rose(ext_bus_oe) |-> !bus_release_ack_n ##[1:ACK_WIN] bus_release_ack_n)
    else $error("acknowledge not dropped after redrive");
  chk_pending_done: assert property (
    $fell(ext_bus_oe) |-> rd_pipe_ff == '0 && beats_ff == 2'h0 && !row_open_ff)
    else $error("bus released with work pending");
  chk_inhibit_holds: assert property (
    release_inhibit && ext_bus_oe |=> ext_bus_oe)
    else $error("bus released while inhibited");
  chk_held_floated: assert property (
    !bus_release_ack_n && !req_n_s |-> !ext_bus_oe && !ext_data_oe)
    else $error("bus driven while released");
  chk_burst_restart: assert property (
    tick && accept && !seq_word |=> beats_ff == BEATS_LEFT)
    else $error("burst counter not reloaded");

  cov_release_cycle: cover property ($fell(ext_bus_oe) ##[1:ACK_WIN] $fell(bus_release_ack_n));
  cov_streamed_word: cover property (tick && accept && seq_word);
  cov_refresh: cover property (tick && ref_issue);
  cov_redrive: cover property ($rose(bus_release_ack_n));

endmodule : ext_mem_sdram_bus_release

// ===== sdram_hold_params.svh
// Constants for the SDRAM burst controller and bus-release handshake.
// Assumes one 100 MHz system clock; all link timing counts are in memory-clock ticks.
`ifndef SDRAM_HOLD_PARAMS_SVH
`define SDRAM_HOLD_PARAMS_SVH

`define MCLK_PERIOD_NS 10
`define ECLK_HALF_DEF 5
`define BANK_W 2
`define ROW_W 12
`define COL_W 8
`define ACC_ADDR_W 22
`define PIN_ADDR_W 20
`define DATA_W 32
`define AP_BIT 10
`define BANK_LSB 12
`define BURST_WORDS 4
`define CAS_LAT_DEF 3
`define REFRESH_TICKS_DEF 780
`define MODE_WORD 20'h0_0032
`define FLOAT_MIN_E 2
`define ACK_MAX_E 2
`define DRIVE_MIN_E 2
`define DRIVE_MAX_E 7
`define CNT_SAT 3'h7

`endif

// ===== sdram_hold_pkg.sv
// Types shared by the SDRAM bus-release design.
// Assumes nothing beyond the constants header.
package sdram_hold_pkg;

  typedef enum logic [7:0] {
    ST_INIT_PRE = 8'h01,
    ST_INIT_REF = 8'h02,
    ST_INIT_MRS = 8'h04,
    ST_RUN      = 8'h08,
    ST_HOLD_WAIT = 8'h10,
    ST_FLOATED  = 8'h20,
    ST_HELD     = 8'h40,
    ST_REDRIVE  = 8'h80
  } state_t;

  // Encoded as {row strobe, column strobe, write enable}, all active low
  typedef enum logic [2:0] {
    mode_reg_set_cmd    = 3'h0,
    refresh_cmd         = 3'h1,
    close_bank_cmd      = 3'h2,
    row_activate_cmd    = 3'h3,
    write_cmd           = 3'h4,
    read_cmd            = 3'h5,
    nop_cmd             = 3'h7
  } cmd_t;

  typedef struct packed {
    logic [3:0] chip_enable_n;
    logic [3:0] byte_enable_n;
    logic [19:0] ext_word_address;
    logic outen_rowstrobe_pin;
    logic read_colstrobe_pin;
    logic write_strobe_pin;
  } pins_t;

endpackage : sdram_hold_pkg

// ===== pin_sync3.sv
// Three-stage synchroniser for a pin from outside the clock domain.
// Output changes only once stages two and three agree.
module pin_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level <= s3_ff;
      end
    end
  end
endmodule : pin_sync3

// ===== eclk_divider.sv
// Divides the system clock into the external memory clock.
// Tick is a one-cycle enable at each rising edge of the divided clock.
module eclk_divider #(
  parameter int HALF = 5
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic clk_out,
  output logic tick
);
  logic [7:0] cnt_ff;
  wire wrap = (cnt_ff == 8'(HALF - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      clk_out <= 1'b0;
      tick <= 1'b0;
    end else begin
      cnt_ff <= wrap ? 8'h00 : cnt_ff + 8'h01;
      if (wrap) begin
        clk_out <= ~clk_out;
      end
      tick <= wrap & ~clk_out;
    end
  end
endmodule : eclk_divider

// ===== sdram_far_model.sv
// Behavioural SDRAM on chip enable 0, plus the level of the shared data wire.
// Assumes pins change only with the memory clock rising, so they are sampled as it falls.
module sdram_far_model #(
  parameter int CAS_LAT = 3
) (
  input wire logic ext_mem_clock_out,
  input wire sdram_hold_pkg::pins_t ext_pins,
  input wire logic ext_bus_oe,
  input wire logic [31:0] ext_data_out,
  input wire logic ext_data_oe,
  output logic [31:0] bus_level,
  output logic [7:0] cmd_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [logic [21:0]];
  logic [11:0] open_row [4] = '{default: 12'h0};
  logic [21:0] base_ff = 22'h0;
  logic [2:0] cnt_ff = 3'h4;
  logic wr_ff = 1'b0;
  logic [CAS_LAT-1:0] pv_ff = '0;
  logic [31:0] pd_ff [CAS_LAT];
  logic [31:0] rdata_ff = 32'h0;
  sdram_hold_pkg::cmd_t cmd;
  wire logic [19:0] a = ext_pins.ext_word_address;
  wire logic sel = ext_bus_oe && !ext_pins.chip_enable_n[0];
  // shared strobes read as row, column, write
  assign cmd = sdram_hold_pkg::cmd_t'({ext_pins.outen_rowstrobe_pin,
      ext_pins.read_colstrobe_pin, ext_pins.write_strobe_pin});
  // Idle wire shows a changing pattern so a stale value never passes for data
  assign bus_level = ext_data_oe ? ext_data_out : rdata_ff;
  initial cmd_seen = 8'h0;
  always @(negedge ext_mem_clock_out) begin
    logic [21:0] k;
    logic [2:0] slot;
    logic go;
    slot = (cmd == sdram_hold_pkg::close_bank_cmd && a[10]) ? 3'h7 : 3'(cmd);
    if (sel && cmd != sdram_hold_pkg::nop_cmd) cmd_seen[slot] = 1'b1;
    if (sel && cmd == sdram_hold_pkg::row_activate_cmd) open_row[a[13:12]] = a[11:0];
    // own burst counter, restarted by any new access
    if (sel && (cmd == sdram_hold_pkg::read_cmd || cmd == sdram_hold_pkg::write_cmd)) begin
      base_ff = {a[13:12], open_row[a[13:12]], a[7:0]};
      cnt_ff = 3'h0;
      wr_ff = (cmd == sdram_hold_pkg::write_cmd);
    end else if (sel && cmd != sdram_hold_pkg::nop_cmd) begin
      cnt_ff = 3'h4;
    end
    go = (cnt_ff < 3'h4);
    k = {base_ff[21:2], base_ff[1:0] + cnt_ff[1:0]};
    if (go && !mem.exists(k)) mem[k] = 32'h0;
    for (int b = 0; b < 4; b++) begin
      if (go && wr_ff && ext_data_oe && !ext_pins.byte_enable_n[b]) begin
        mem[k][8*b +: 8] = ext_data_out[8*b +: 8];
      end
    end
    if (go) cnt_ff = cnt_ff + 3'h1;
    for (int i = CAS_LAT - 1; i > 0; i--) pd_ff[i] = pd_ff[i-1];
    pd_ff[0] = go ? mem[k] : 32'h0;
    pv_ff = {pv_ff[CAS_LAT-2:0], go && !wr_ff};
    rdata_ff = pv_ff[CAS_LAT-1] ? pd_ff[CAS_LAT-1] : ~rdata_ff;
  end
endmodule : sdram_far_model

// ===== ext_mem_sdram_bus_release_bench.sv
// Self-checking bench for the SDRAM burst and bus-release block.
// Assumes the far-side memory model; 125 ns is not reachable, so the memory clock is 120 ns.
module ext_mem_sdram_bus_release_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 6;
  localparam int E = 2 * HALF;
  localparam logic [21:0] ROW_A = 22'h10_0310;
  localparam logic [21:0] ROW_B = 22'h10_0520;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic bus_release_req_n = 1'b1;
  logic release_inhibit = 1'b0;
  logic acc_valid = 1'b0;
  logic acc_write = 1'b0;
  logic [21:0] acc_addr = 22'h0;
  logic [31:0] acc_wdata = 32'h0;
  logic [3:0] acc_be_n = 4'h0;
  logic bus_release_ack_n, ext_mem_clock_out, ext_bus_oe, ext_data_oe;
  logic acc_ready, rd_valid;
  logic [31:0] ext_data_in, ext_data_out, rd_data;
  logic [7:0] cmd_seen;
  sdram_hold_pkg::pins_t ext_pins;
  logic [31:0] exp_mem [logic [21:0]];
  logic [31:0] rq [$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int last_acc = 0;

  ext_mem_sdram_bus_release #(.ECLK_HALF(HALF), .CAS_LAT(3)) dut_u (.mclk(mclk),
    .rst_n(rst_n), .bus_release_req_n(bus_release_req_n), .release_inhibit(release_inhibit),
    .bus_release_ack_n(bus_release_ack_n), .ext_mem_clock_out(ext_mem_clock_out),
    .ext_pins(ext_pins), .ext_bus_oe(ext_bus_oe), .ext_data_in(ext_data_in),
    .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_be_n(acc_be_n),
    .acc_ready(acc_ready), .rd_valid(rd_valid), .rd_data(rd_data));
  sdram_far_model #(.CAS_LAT(3)) far_u (.ext_mem_clock_out(ext_mem_clock_out),
    .ext_pins(ext_pins), .ext_bus_oe(ext_bus_oe), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .bus_level(ext_data_in), .cmd_seen(cmd_seen));

  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc++;
  always @(negedge mclk) if (rd_valid === 1'b1) rq.push_back(rd_data);

  task automatic tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic in_range(string what, int lo, int hi, int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : in_range

  function automatic logic probe(int k);
    return (k == 0) ? ext_bus_oe : (k == 1) ? bus_release_ack_n : acc_ready;
  endfunction : probe

  // Counts falling edges until the probed output shows lvl; gives up after 2000
  task automatic wait_for(int k, logic lvl, output int n);
    n = 0;
    while (probe(k) !== lvl && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 2000) check("wait limit", 32'(lvl), ~32'(lvl));
  endtask : wait_for

  // Leaves acc_valid high so the next word can follow on the very next tick
  task automatic push(logic w, logic [21:0] ad, logic [31:0] d, logic [3:0] be, output int gap);
    int n;
    acc_valid = 1'b1;
    acc_write = w;
    acc_addr = ad;
    acc_wdata = d;
    acc_be_n = be;
    #1;
    wait_for(2, 1'b1, n);
    gap = cyc - last_acc;
    last_acc = cyc;
    @(negedge mclk);
  endtask : push

  task automatic idle();
    acc_valid = 1'b0;
    @(negedge mclk);
  endtask : idle

  task automatic burst(logic w, logic [21:0] base, logic [7:0] order, logic [3:0] tail_be);
    int gap;
    logic [21:0] ad;
    logic [31:0] d;
    rq.delete();
    for (int i = 0; i < 4; i++) begin
      ad = base + 22'(order[2*i +: 2]);
      d = {ad[15:0], 16'hC3A5};
      push(w, ad, d, (i == 3) ? tail_be : 4'h0, gap);
      if (i > 0) in_range("word gap", E, E, gap);
      if (w && !exp_mem.exists(ad)) exp_mem[ad] = 32'h0;
      for (int b = 0; b < 4; b++) if (w && !tail_be[b] | i < 3) exp_mem[ad][8*b +: 8] = d[8*b +: 8];
    end
    idle();
    for (int t = 0; t < 8 * E && rq.size() < 4 && !w; t++) @(negedge mclk);
    for (int i = 0; i < 4 && !w; i++) begin
      check("read word", exp_mem[base + 22'(order[2*i +: 2])], rq[i]);
    end
  endtask : burst

  task automatic write_then_read_orders();
    burst(1'b1, ROW_A, 8'hE4, 4'hC);
    burst(1'b0, ROW_A, 8'hE4, 4'h0);
    burst(1'b0, ROW_A, 8'h72, 4'h0);
    burst(1'b0, ROW_A, 8'h1B, 4'h0);
    burst(1'b1, ROW_B, 8'hE4, 4'h0);
    burst(1'b0, ROW_A, 8'h1B, 4'h0);
  endtask : write_then_read_orders

  task automatic hold_idle();
    int n;
    int m;
    int bad;
    bad = 0;
    bus_release_req_n = 1'b0;
    wait_for(0, 1'b0, n);
    in_range("float delay", 2 * E, 5 * E, n);
    wait_for(1, 1'b0, m);
    in_range("ack after float", 0, 2 * E, m);
    // request kept low well past one period
    repeat (5 * E) begin
      @(negedge mclk);
      if (ext_bus_oe !== 1'b0 || bus_release_ack_n !== 1'b0 || ext_data_oe !== 1'b0) bad++;
    end
    check("floated while held", 32'h0, 32'(bad));
    bus_release_req_n = 1'b1;
    wait_for(0, 1'b1, n);
    in_range("redrive delay", 2 * E, 7 * E, n);
    wait_for(1, 1'b1, m);
    in_range("ack release", 0, 2 * E, m);
  endtask : hold_idle

  task automatic hold_busy();
    int n;
    int gap;
    rq.delete();
    push(1'b0, ROW_A, 32'h0, 4'h0, gap);
    idle();
    bus_release_req_n = 1'b0;
    wait_for(1, 1'b0, n);
    check("reads done before ack", 32'h1, 32'(rq.size()));
    check("held read word", exp_mem[ROW_A], rq[0]);
    // request kept low past one period
    repeat (2 * E) @(negedge mclk);
    bus_release_req_n = 1'b1;
    wait_for(1, 1'b1, n);
  endtask : hold_busy

  task automatic hold_inhibited();
    int bad;
    bad = 0;
    release_inhibit = 1'b1;
    bus_release_req_n = 1'b0;
    repeat (20 * E) begin
      @(negedge mclk);
      if (bus_release_ack_n !== 1'b1 || ext_bus_oe !== 1'b1) bad++;
    end
    check("inhibited release", 32'h0, 32'(bad));
    bus_release_req_n = 1'b1;
    // Let the raised request pass the synchroniser before inhibit drops
    repeat (E) @(negedge mclk);
    release_inhibit = 1'b0;
  endtask : hold_inhibited

  initial begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    write_then_read_orders();
    hold_idle();
    hold_busy();
    hold_inhibited();
    burst(1'b0, ROW_B, 8'h72, 4'h0);
    check("commands seen", 32'h0000_00BF, 32'(cmd_seen));
    tally_and_finish();
  end

  // Whole run needs about 15 us; twenty times that means a hang
  initial begin
    #300_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : ext_mem_sdram_bus_release_bench
